// *** src/reset_cause_flag_register.sv ***
// reset-cause flag register with event status, mask and watchdog, on APB
// assumes presetn is the power-on reset and event inputs are one-cycle pulses
// synchronous to pclk

// Summary of operation
// - trap, illegal-op, config flags: set, POR-cleared
// - pin and soft reset flags: set, POR-cleared
// - watchdog flag: power-save instruction or POR clears
// - power-save sets sleep or idle flag
// - idle flag shows device was idle
// - brown-out flag set by brown-out and POR
// - power-on flag set by POR or a software flag write
// - software writes flags, never causes reset
// - fuse enable forces watchdog always running
module reset_cause_flag_register #(
    parameter int TICK_LEN = reset_cause_pkg::TICK_CYCLES,
    parameter int WDOG_PERIOD = reset_cause_pkg::WDOG_PERIOD_TICKS
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [reset_cause_pkg::ADDR_W-1:0] paddr,
    input wire logic [reset_cause_pkg::DATA_W-1:0] pwdata,
    output logic [reset_cause_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // reset and power events
    input wire logic trap_conflict_evt,
    input wire logic illegal_op_evt,
    input wire logic config_mismatch_evt,
    input wire logic master_clear_pin,
    input wire logic soft_reset_evt,
    input wire logic brownout_evt,
    input wire logic power_save_instruction,
    input wire logic power_save_sleep,
    // watchdog
    input wire logic wdog_fuse_enable,
    output logic wdog_timeout,
    // interrupt
    output logic irq
);
    import reset_cause_pkg::*;

    // refused at elaboration: a zero-length tick or period would never expire
    if (TICK_LEN < 1 || WDOG_PERIOD < 1) begin : g_bad_params
        $error("reset_cause_flag_register: tick length and period must be at least 1");
    end

    logic [FLAG_W-1:0] flags_ff;
    logic [FLAG_W-1:0] nxt_flags;
    logic [FLAG_W-1:0] status_ff;
    logic [FLAG_W-1:0] nxt_status;
    logic [FLAG_W-1:0] mask_ff;
    logic [FLAG_W-1:0] nxt_mask;
    logic wdog_soft_en_ff;
    logic nxt_wdog_soft_en;
    logic [DATA_W-1:0] prdata_ff;
    logic [DATA_W-1:0] nxt_prdata;
    logic pready_ff;
    logic nxt_pready;
    logic pslverr_ff;
    logic nxt_pslverr;
    logic irq_ff;
    logic nxt_irq;
    logic wdog_expired_ff;

    logic access;
    logic done;
    logic addr_hit;
    logic wr_flags;
    logic wr_mask;
    logic wr_wdog;
    logic rd_status;
    logic wdog_run;
    logic wdog_restart;
    logic [FLAG_W-1:0] hw_set;
    logic [FLAG_W-1:0] hw_clr;
    logic [FLAG_W-1:0] wr_value;
    logic [DATA_W-1:0] rd_word;

    // apb decode: one wait state, the transfer ends on the second access cycle
    always_comb begin
        access = psel && penable;
        done = access && pready_ff;
        addr_hit = (paddr == OFS_FLAGS) || (paddr == OFS_EVT_STATUS) ||
                   (paddr == OFS_EVT_MASK) || (paddr == OFS_WDOG_CTRL);
        wr_flags = done && pwrite && (paddr == OFS_FLAGS);
        wr_mask = done && pwrite && (paddr == OFS_EVT_MASK);
        wr_wdog = done && pwrite && (paddr == OFS_WDOG_CTRL);
        rd_status = done && !pwrite && (paddr == OFS_EVT_STATUS);
        wr_value = pwdata[FLAG_W-1:0] & FLAGS_IMPL;
    end

    // hardware set and clear events, in the layout of the flag register
    always_comb begin
        hw_set = '0;
        hw_clr = '0;
        hw_set[BIT_TRAP] = trap_conflict_evt;
        hw_set[BIT_ILLOP] = illegal_op_evt;
        hw_set[BIT_CFGMM] = config_mismatch_evt;
        hw_set[BIT_EXT_PIN_RESET_FLAG] = master_clear_pin;
        hw_set[BIT_SOFTR] = soft_reset_evt;
        hw_set[BIT_WDOG_TIMEOUT_FLAG] = wdog_expired_ff;
        hw_clr[BIT_WDOG_TIMEOUT_FLAG] = power_save_instruction;
        hw_set[BIT_SLEEP] = power_save_instruction && power_save_sleep;
        hw_set[BIT_IDLE] = power_save_instruction && !power_save_sleep;
        hw_set[BIT_BROWN] = brownout_evt;
    end

    // flags: only presetn or a flag write clears the POR-only group; the power-on and
    // brown-out flags come out of reset set
    always_comb begin
        nxt_flags = flags_ff & ~hw_clr;
        if (wr_flags) begin
            nxt_flags = wr_value;
        end
        nxt_flags = nxt_flags | hw_set;
    end

    // event status: read-clear removes only the bits that the read returned,
    // so an event landing between capture and clear is kept
    always_comb begin
        nxt_status = status_ff;
        if (rd_status) begin
            nxt_status = status_ff & ~prdata_ff[FLAG_W-1:0];
        end
        nxt_status = nxt_status | hw_set;
        nxt_mask = wr_mask ? wr_value : mask_ff;
        nxt_irq = |(status_ff & mask_ff);
    end

    // watchdog control; a flag write never touches the watchdog or a reset
    always_comb begin
        nxt_wdog_soft_en = wdog_soft_en_ff;
        if (wr_wdog) begin
            nxt_wdog_soft_en = pwdata[BIT_WDOG_SOFT_EN];
        end
        wdog_run = wdog_fuse_enable || wdog_soft_en_ff;
        wdog_restart = power_save_instruction || (wr_wdog && pwdata[BIT_WDOG_KICK]);
    end

    // read mux; captured one cycle before the transfer completes
    always_comb begin
        rd_word = '0;
        unique case (paddr)
            OFS_FLAGS: rd_word[FLAG_W-1:0] = flags_ff;
            OFS_EVT_STATUS: rd_word[FLAG_W-1:0] = status_ff;
            OFS_EVT_MASK: rd_word[FLAG_W-1:0] = mask_ff;
            OFS_WDOG_CTRL: begin
                rd_word[BIT_WDOG_SOFT_EN] = wdog_soft_en_ff;
                rd_word[BIT_WDOG_RUN] = wdog_run;
            end
            default: rd_word = '0;
        endcase
    end

    always_comb begin
        nxt_pready = access && !pready_ff;
        nxt_pslverr = 1'b0;
        nxt_prdata = prdata_ff;
        if (access && !pready_ff) begin
            nxt_pslverr = !addr_hit;
            nxt_prdata = pwrite ? '0 : rd_word;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= FLAGS_RST;
            status_ff <= EVT_STATUS_RST;
            mask_ff <= EVT_MASK_RST;
            wdog_soft_en_ff <= WDOG_SOFT_EN_RST;
            prdata_ff <= '0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            flags_ff <= nxt_flags;
            status_ff <= nxt_status;
            mask_ff <= nxt_mask;
            wdog_soft_en_ff <= nxt_wdog_soft_en;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            irq_ff <= nxt_irq;
        end
    end

    wdog_counter #(
        .TICK_LEN(TICK_LEN),
        .PERIOD(WDOG_PERIOD)
    ) u_wdog (
        .pclk(pclk),
        .presetn(presetn),
        .run(wdog_run),
        .restart(wdog_restart),
        .expired_ff(wdog_expired_ff)
    );

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
    assign wdog_timeout = wdog_expired_ff;

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_trap_flags_set: assert property (
        (trap_conflict_evt || illegal_op_evt || config_mismatch_evt) |=>
        (flags_ff[BIT_TRAP] == $past(trap_conflict_evt) || flags_ff[BIT_TRAP]) &&
        (flags_ff[BIT_ILLOP] || !$past(illegal_op_evt)) &&
        (flags_ff[BIT_CFGMM] || !$past(config_mismatch_evt)))
        else $error("trap, illegal-op or config flag not set");

    a_por_only_hold: assert property (
        !wr_flags |=> ((~flags_ff & $past(flags_ff) & FLAGS_POR_ONLY) == '0))
        else $error("POR-only flag cleared without reset or write");

    a_reset_src_set: assert property (
        (master_clear_pin || soft_reset_evt) |=>
        (flags_ff[BIT_EXT_PIN_RESET_FLAG] || !$past(master_clear_pin)) &&
        (flags_ff[BIT_SOFTR] || !$past(soft_reset_evt)))
        else $error("pin or soft reset flag not set");

    a_wdog_timeout_flag_cleared: assert property (
        (power_save_instruction && !wdog_expired_ff && !wr_flags) |=>
        !flags_ff[BIT_WDOG_TIMEOUT_FLAG])
        else $error("watchdog flag not cleared by power-save");

    a_wdog_timeout_flag_set: assert property (
        wdog_expired_ff |=> flags_ff[BIT_WDOG_TIMEOUT_FLAG] && status_ff[BIT_WDOG_TIMEOUT_FLAG])
        else $error("watchdog expiry not recorded");

    a_sleep_idle_set: assert property (
        power_save_instruction |=>
        ($past(power_save_sleep) ? flags_ff[BIT_SLEEP] : flags_ff[BIT_IDLE]))
        else $error("power-save mode flag not set");

    a_idle_stays: assert property (
        (flags_ff[BIT_IDLE] && !wr_flags) [*2] |=> flags_ff[BIT_IDLE])
        else $error("idle flag dropped without software");

    a_brownout_set: assert property (
        brownout_evt |=> flags_ff[BIT_BROWN] ##1 (flags_ff[BIT_BROWN] || $past(wr_flags)))
        else $error("brown-out flag not set or lost");

    a_por_flag_hold: assert property (
        (flags_ff[BIT_POR] && !wr_flags) |=> flags_ff[BIT_POR])
        else $error("power-on flag cleared by hardware");

    // a flag write must leave every other register alone: no side reset
    a_sw_write_flags: assert property (
        (wr_flags && hw_set == '0 && !hw_clr[BIT_WDOG_TIMEOUT_FLAG]) |=>
        flags_ff == $past(wr_value) && $stable(mask_ff) && $stable(status_ff) &&
        $stable(wdog_soft_en_ff))
        else $error("software flag write not stored");

    a_wdog_fuse_run: assert property (
        wdog_fuse_enable |-> wdog_run)
        else $error("watchdog stopped while fuse enable set");

    a_set_wins: assert property (
        (wr_flags && hw_set != '0) |=> ((flags_ff & $past(hw_set)) == $past(hw_set)))
        else $error("software write overrode hardware set");

    a_apb_wait: assert property (
        (access && !pready_ff) |=> pready_ff ##1 !pready_ff)
        else $error("apb answer not one wait state");

    a_ready_source: assert property (
        pready_ff |-> $past(access && !pready_ff))
        else $error("ready without a pending access");

    a_slverr_decode: assert property (
        (access && !pready_ff) |=> (pslverr_ff == !$past(addr_hit)))
        else $error("error response does not match the address decode");

    a_slverr_pulse: assert property (
        pslverr_ff |-> pready_ff)
        else $error("error response outside the ready cycle");

    a_unmapped_ignored: assert property (
        (done && pwrite && !addr_hit && hw_set == '0 && !power_save_instruction) |=>
        $stable(flags_ff) && $stable(mask_ff) && $stable(wdog_soft_en_ff))
        else $error("write to an unmapped address changed a register");

    a_upper_zero: assert property (
        prdata_ff[DATA_W-1:FLAG_W] == '0)
        else $error("read data above the flag width not zero");

    a_flags_unimpl: assert property (
        (flags_ff & ~FLAGS_IMPL) == '0)
        else $error("unimplemented flag bit set");

    a_irq_level: assert property (
        ((status_ff & mask_ff) != '0) |=> irq_ff)
        else $error("unmasked event without interrupt");

    a_irq_quiet: assert property (
        ((status_ff & mask_ff) == '0) |=> !irq_ff)
        else $error("interrupt without unmasked event");

    // set wins over a read clear in the same cycle
    a_status_set: assert property (
        (hw_set != '0) |=> ((status_ff & $past(hw_set)) == $past(hw_set)))
        else $error("event not recorded in status");

    a_status_read_clear: assert property (
        (rd_status && hw_set == '0) |=> ((status_ff & $past(prdata_ff[FLAG_W-1:0])) == '0))
        else $error("status bits not cleared by read");

    a_status_hold: assert property (
        !rd_status |=> ((~status_ff & $past(status_ff)) == '0))
        else $error("status bit lost without a read");

    a_mask_write: assert property (
        wr_mask |=> (mask_ff == $past(wr_value)))
        else $error("mask write not stored");

    a_mask_hold: assert property (
        !wr_mask |=> $stable(mask_ff))
        else $error("mask changed without a write");

    a_wdog_ctrl_write: assert property (
        wr_wdog |=> (wdog_soft_en_ff == $past(pwdata[BIT_WDOG_SOFT_EN])))
        else $error("watchdog enable write not stored");

    a_wdog_idle: assert property (
        !wdog_run |=> !wdog_expired_ff)
        else $error("watchdog expired while stopped");

    a_wdog_restart: assert property (
        wdog_restart |=> !wdog_expired_ff)
        else $error("watchdog expired right after a restart");

    c_write_flags: cover property (wr_flags ##1 flags_ff[BIT_POR] == 1'b0);
    c_status_read_clear: cover property (rd_status ##1 status_ff == '0);
    c_wdog_expire: cover property (wdog_expired_ff ##1 flags_ff[BIT_WDOG_TIMEOUT_FLAG]);
    c_set_and_write: cover property (wr_flags && trap_conflict_evt);
    c_irq_raised: cover property ($rose(irq_ff));
endmodule

// *** src/reset_cause_pkg.sv ***
// constants for the reset-cause flag register block
// assumes a 50 MHz pclk and a 32-bit APB master on the register side
package reset_cause_pkg;
    // clock and timing
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = (TICK_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int WDOG_PERIOD_US = 1000;
    localparam int WDOG_PERIOD_TICKS = (WDOG_PERIOD_US * 1000) / TICK_NS;

    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int FLAG_W = 16;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_WDOG_CTRL = 8'h0C;

    // flag positions in reset_cause_flags
    localparam int BIT_TRAP = 15;
    localparam int BIT_ILLOP = 14;
    localparam int BIT_CFGMM = 9;
    localparam int BIT_EXT_PIN_RESET_FLAG = 7;
    localparam int BIT_SOFTR = 6;
    localparam int BIT_WDOG_TIMEOUT_FLAG = 4;
    localparam int BIT_SLEEP = 3;
    localparam int BIT_IDLE = 2;
    localparam int BIT_BROWN = 1;
    localparam int BIT_POR = 0;

    // watchdog control fields
    localparam int BIT_WDOG_SOFT_EN = 0;
    localparam int BIT_WDOG_KICK = 1;
    localparam int BIT_WDOG_RUN = 2;

    // reset values and masks
    localparam logic [FLAG_W-1:0] FLAGS_RST = 16'h0003;
    localparam logic [FLAG_W-1:0] FLAGS_IMPL = 16'hC2DF;
    localparam logic [FLAG_W-1:0] FLAGS_POR_ONLY = 16'hC2C0;
    localparam logic [FLAG_W-1:0] EVT_STATUS_RST = 16'h0000;
    localparam logic [FLAG_W-1:0] EVT_MASK_RST = 16'h0000;
    localparam logic WDOG_SOFT_EN_RST = 1'b0;
endpackage

// *** src/wdog_counter.sv ***
// watchdog period counter with a microsecond tick prescaler
// assumes restart and run are synchronous levels from the parent block
module wdog_counter #(
    parameter int TICK_LEN = reset_cause_pkg::TICK_CYCLES,
    parameter int PERIOD = reset_cause_pkg::WDOG_PERIOD_TICKS
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic run,
    input wire logic restart,
    // result
    output logic expired_ff
);
    import reset_cause_pkg::*;
    localparam int PW = $clog2(TICK_LEN + 1);
    localparam int CW = $clog2(PERIOD + 1);

    if (TICK_LEN < 1 || PERIOD < 1) begin : g_bad_params
        $error("wdog_counter: tick length and period must be at least 1");
    end

    logic [PW-1:0] pre_ff;
    logic [PW-1:0] nxt_pre;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic nxt_expired;
    logic tick;

    always_comb begin
        tick = 1'b0;
        nxt_pre = pre_ff;
        nxt_cnt = cnt_ff;
        nxt_expired = 1'b0;
        if (restart || !run) begin
            nxt_pre = '0;
            nxt_cnt = '0;
        end else begin
            if (pre_ff == PW'(TICK_LEN - 1)) begin
                nxt_pre = '0;
                tick = 1'b1;
            end else begin
                nxt_pre = pre_ff + PW'(1);
            end
            if (tick) begin
                if (cnt_ff == CW'(PERIOD - 1)) begin
                    // expiry restarts the period so a stuck system keeps flagging
                    nxt_cnt = '0;
                    nxt_expired = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff + CW'(1);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_ff <= '0;
            cnt_ff <= '0;
            expired_ff <= 1'b0;
        end else begin
            pre_ff <= nxt_pre;
            cnt_ff <= nxt_cnt;
            expired_ff <= nxt_expired;
        end
    end
endmodule

// *** verif/reset_cause_flag_register_tb.sv ***
// self-checking bench for the reset-cause flag register block
// assumes the one-wait-state apb slave and the register map of the block
`define check(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module reset_cause_flag_register_tb
    import reset_cause_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // shortened watchdog so a period is a handful of cycles
    localparam int TICKS = 2;
    localparam int PERIOD = 4;
    localparam int BITPOS [6] = '{BIT_TRAP, BIT_ILLOP, BIT_CFGMM, BIT_EXT_PIN_RESET_FLAG, BIT_SOFTR, BIT_BROWN};
    int mismatches = 0;
    int n_tests = 0;
    int n;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [DATA_W-1:0] pwdata = 32'h0;
    logic [5:0] evt = 6'h00;
    logic ps_ins = 1'h0;
    logic ps_sleep = 1'h0;
    logic fuse = 1'h0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic wdog_timeout;
    logic irq;
    logic [DATA_W-1:0] rd;
    logic err;

    reset_cause_flag_register #(.TICK_LEN(TICKS), .WDOG_PERIOD(PERIOD)) uut (
        .pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trap_conflict_evt(evt[0]), .illegal_op_evt(evt[1]), .config_mismatch_evt(evt[2]),
        .master_clear_pin(evt[3]), .soft_reset_evt(evt[4]), .brownout_evt(evt[5]),
        .power_save_instruction(ps_ins), .power_save_sleep(ps_sleep),
        .wdog_fuse_enable(fuse), .wdog_timeout(wdog_timeout), .irq(irq)
    );

    always #10 pclk = ~pclk;

    task automatic wrap_up();
        if (mismatches == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // request held unchanged until pready is sampled high
    task automatic apb(input logic we, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= we;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'h1) break;
        end
        if (i == 20) begin
            mismatches++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic pulse(input int k);
        @(posedge pclk);
        evt[k] <= 1'h1;
        @(posedge pclk);
        evt[k] <= 1'h0;
    endtask

    task automatic psave(input logic s);
        @(posedge pclk);
        ps_ins <= 1'h1;
        ps_sleep <= s;
        @(posedge pclk);
        ps_ins <= 1'h0;
    endtask

    // bounded wait for a watchdog expiry, cycles counted in n
    task automatic wait_wdog();
        for (n = 1; n < 40; n++) begin
            @(posedge pclk);
            if (wdog_timeout === 1'h1) break;
        end
        if (n == 40) begin
            mismatches++;
            wrap_up();
        end
    endtask

    task automatic t_reset_values();
        apb(1'h0, OFS_FLAGS, 32'h0);
        `check(rd, 32'h0000_0003)
        apb(1'h0, OFS_EVT_STATUS, 32'h0);
        `check(rd, 32'h0)
        apb(1'h0, OFS_WDOG_CTRL, 32'h0);
        `check(rd, 32'h0)
    endtask

    task automatic t_sw_access();
        apb(1'h1, OFS_EVT_MASK, 32'h0000_00C0);
        apb(1'h1, OFS_FLAGS, 32'h0000_FFFF);
        apb(1'h0, OFS_FLAGS, 32'h0);
        `check(rd, 32'h0000_C2DF)
        apb(1'h0, OFS_EVT_MASK, 32'h0);
        `check(rd, 32'h0000_00C0)
        apb(1'h1, OFS_FLAGS, 32'h0);
        apb(1'h0, OFS_FLAGS, 32'h0);
        `check(rd, 32'h0)
        apb(1'h1, OFS_EVT_MASK, 32'h0);
    endtask

    // each event alone, then all six one after another and a power-save that must spare them
    task automatic t_events();
        for (int k = 0; k < 6; k++) begin
            apb(1'h1, OFS_FLAGS, 32'h0);
            pulse(k);
            apb(1'h0, OFS_FLAGS, 32'h0);
            `check(rd, 32'h1 << BITPOS[k])
        end
        for (int k = 0; k < 6; k++) pulse(k);
        psave(1'h1);
        apb(1'h0, OFS_FLAGS, 32'h0);
        `check(rd, 32'h0000_C2CA)
    endtask

    task automatic t_power_save();
        apb(1'h1, OFS_FLAGS, 32'h0);
        psave(1'h1);
        apb(1'h0, OFS_FLAGS, 32'h0);
        `check(rd, 32'h0000_0008)
        apb(1'h1, OFS_FLAGS, 32'h0);
        psave(1'h0);
        apb(1'h0, OFS_FLAGS, 32'h0);
        `check(rd, 32'h0000_0004)
        apb(1'h1, OFS_FLAGS, 32'h0000_0010);
        psave(1'h1);
        apb(1'h0, OFS_FLAGS, 32'h0);
        `check(rd, 32'h0000_0008)
    endtask

    task automatic t_watchdog();
        apb(1'h1, OFS_FLAGS, 32'h0);
        @(posedge pclk);
        fuse <= 1'h1;
        wait_wdog();
        `check(n >= TICKS * PERIOD - 1 && n <= TICKS * PERIOD + 2, 1'h1)
        apb(1'h0, OFS_FLAGS, 32'h0);
        `check(rd, 32'h0000_0010)
        apb(1'h0, OFS_WDOG_CTRL, 32'h0);
        `check(rd[2], 1'h1)
        @(posedge pclk);
        fuse <= 1'h0;
        apb(1'h1, OFS_FLAGS, 32'h0);
        repeat (30) @(posedge pclk);
        apb(1'h0, OFS_FLAGS, 32'h0);
        `check(rd, 32'h0)
        apb(1'h1, OFS_WDOG_CTRL, 32'h1);
        wait_wdog();
        // a kick restarts the period, so the next expiry is a full period away
        apb(1'h1, OFS_WDOG_CTRL, 32'h3);
        wait_wdog();
        `check(n, TICKS * PERIOD + 1)
        apb(1'h1, OFS_WDOG_CTRL, 32'h0);
        apb(1'h0, OFS_FLAGS, 32'h0);
        `check(rd, 32'h0000_0010)
    endtask

    // trap event lands on the very edge that commits a clearing write
    task automatic t_precedence();
        apb(1'h1, OFS_FLAGS, 32'h0);
        fork
            apb(1'h1, OFS_FLAGS, 32'h0);
            begin
                repeat (3) @(posedge pclk);
                evt[0] <= 1'h1;
                @(posedge pclk);
                evt[0] <= 1'h0;
            end
        join
        apb(1'h0, OFS_FLAGS, 32'h0);
        `check(rd, 32'h0000_8000)
    endtask

    task automatic t_irq_and_errors();
        apb(1'h0, OFS_EVT_STATUS, 32'h0);
        apb(1'h1, OFS_EVT_MASK, 32'h0000_0080);
        pulse(4);
        repeat (3) @(posedge pclk);
        `check(irq, 1'h0)
        pulse(3);
        repeat (2) @(posedge pclk);
        `check(irq, 1'h1)
        apb(1'h0, OFS_EVT_STATUS, 32'h0);
        `check(rd, 32'h0000_00C0)
        repeat (2) @(posedge pclk);
        `check(irq, 1'h0)
        apb(1'h0, 8'h10, 32'h0);
        `check({err, rd}, 33'h1_0000_0000)
        apb(1'h1, 8'h14, 32'h0000_FFFF);
        `check(err, 1'h1)
    endtask

    // power-on reset in mid-run after every flag was set
    task automatic t_por();
        apb(1'h1, OFS_FLAGS, 32'h0000_FFFF);
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, OFS_FLAGS, 32'h0);
        `check(rd, 32'h0000_0003)
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        wrap_up();
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        t_reset_values();
        t_sw_access();
        t_events();
        t_power_save();
        t_watchdog();
        t_precedence();
        t_irq_and_errors();
        t_por();
        wrap_up();
    end
endmodule
